// ==== hdl/gfx_addr_pixel.sv ====
// Graphics scan addressing, pixel decode and controller write filter.
// Assumes video memory answers a fetch request on the next cycle.
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// R1 - Low mode shows 320 by 200 pixels, two bits each.
// R2 - Low mode repeats each row on the following odd scan.
// R3 - 200-row even rows from base bank, odd rows 0x2000 higher.
// R4 - Low mode bytes hold four adjacent pixels, first byte leftmost.
// R5 - Upper bit red, lower green; zero pixel shows background.
// R6 - Foreground blue follows colour-select bit 5.
// R7 - Mono bit in low mode gives a third palette.
// R8 - Start address zero means base; nonzero shifts to another page.
// R9 - Page bit picks 32 KB half when 64 KB present.
// R10 - Lower window holds further even/odd bank pairs.
// R11 - Medium mode: one bit per pixel, eight per byte.
// R12 - High colour: scan mod 4 picks bank B8000,BC000,A8000,AC000.
// R13 - High colour: two bits per pixel, top bits first.
// R14 - High mono: one bit per pixel, image two in lower window.
// R15 - High mono: four 8 KB banks, every fourth scan each.
// R16 - Graphics cursor start 0..7 doubled, end 0..7 becomes 2n+1, 8..15 unchanged.
// R17 - Software keeps cursor start not above cursor end.
// R18 - Timing registers 0..9 forced to adapter values.
// R19 - Host writes index first, then data.
// R20 - Colour-select low bits are background; bit 5 picks palette.
// R21 - Pixels leave each byte most significant first.
module gfx_addr_pixel
  import gfx_pkg::*;
#(
  parameter int ADDR_W = 17
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic scan_start_i,
  input wire logic [8:0] scan_i,
  output logic [ADDR_W-1:0] vmem_addr_o,
  output logic vmem_req_o,
  input wire logic [7:0] vmem_data_i,
  output logic red_o,
  output logic green_o,
  output logic blue_o,
  output logic inten_o,
  output logic pixel_valid_o,
  output logic crtc_we_o,
  output logic [4:0] crtc_reg_o,
  output logic [7:0] crtc_data_o
);
  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_SHIFT} fetch_e;
  logic [7:0] ctrl_q;
  logic [7:0] colsel_q;
  logic [13:0] start_q;
  logic [4:0] idx_q;
  logic ack_q;
  logic [31:0] rdata_q;
  fetch_e st_q;
  logic [7:0] col_q;
  logic [7:0] col_last;
  logic ld_q;
  logic [8:0] scan_q;
  logic [7:0] shift_q;
  logic [2:0] pix_q;
  logic [ADDR_W-1:0] addr_q;
  logic req_q;
  logic r_q, g_q, b_q, i_q, v_q;
  logic cwe_q;
  logic [4:0] creg_q;
  logic [7:0] cdat_q;
  gfx_mode_e mode;
  logic sel;
  logic two_bit;
  logic [ADDR_W-1:0] bank_base;
  logic [13:0] row_off;
  logic [7:0] conv;
  logic [3:0] cur_v;

  assign mode = gfx_mode_e'(ctrl_q[MODE_LSB +: 2]);
  assign two_bit = (mode == MODE_LOW) || (mode == MODE_HICOL); // R1 R13
  assign sel = avs_read_i | avs_write_i;
  // High colour rows are twice as wide in bytes
  assign col_last = (mode == MODE_HICOL) ? 8'(2 * BYTES_ROW - 1)
                                         : 8'(BYTES_ROW - 1); // R13

  // Avalon slave: one wait cycle per access, then acknowledge
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= sel & ~ack_q;
    end
  end
  assign avs_waitrequest_o = ~ack_q;

  // Register writes
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= CTRL_RST;
      colsel_q <= COLSEL_RST;
      start_q <= START_RST;
      idx_q <= 5'h00;
    end else if (avs_write_i && ack_q) begin
      case ({avs_address_i, 2'b00})
        CTRL_OFS: ctrl_q <= avs_writedata_i[7:0];
        COLSEL_OFS: colsel_q <= avs_writedata_i[7:0];
        START_OFS: start_q <= avs_writedata_i[13:0]; // R8
        CRTC_IDX_OFS: idx_q <= avs_writedata_i[4:0]; // R19
        default: ;
      endcase
    end
  end

  // Read data, unmapped words read zero
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      case ({avs_address_i, 2'b00})
        CTRL_OFS: rdata_q <= {24'h000000, ctrl_q};
        COLSEL_OFS: rdata_q <= {24'h000000, colsel_q};
        START_OFS: rdata_q <= {18'h00000, start_q};
        CRTC_IDX_OFS: rdata_q <= {18'h00000, scan_q, idx_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata_o = rdata_q;

  // Cursor translation for graphics modes
  always_comb begin
    cur_v = avs_writedata_i[3:0];
    if (!cur_v[3]) begin
      conv = {3'b000, cur_v[2:0], 2'b00} >> 1; // R16 becomes 2n
    end else begin
      conv = {4'h0, cur_v}; // R16
    end
  end

  // Controller write filter
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cwe_q <= 1'b0;
      creg_q <= 5'h00;
      cdat_q <= 8'h00;
    end else begin
      cwe_q <= 1'b0;
      if (avs_write_i && ack_q && {avs_address_i, 2'b00} == CRTC_DAT_OFS)
      begin
        cwe_q <= 1'b1;
        creg_q <= idx_q;
        cdat_q <= avs_writedata_i[7:0];
        if (idx_q <= TIMING_LAST) begin
          if (mode == MODE_LOW || mode == MODE_MED) begin
            cdat_q <= TIM200[idx_q[3:0]]; // R18
          end else begin
            cdat_q <= TIM400[idx_q[3:0]]; // R18
          end
        end else if (idx_q == CUR_START_REG) begin
          cdat_q <= {avs_writedata_i[7:4], conv[3:0]}; // R16 R17
        end else if (idx_q == CUR_END_REG) begin
          cdat_q <= {avs_writedata_i[7:4], conv[3:0] | {3'b000, ~cur_v[3]}}; // R16
        end
      end
    end
  end

  // Bank base per mode and scan
  always_comb begin
    row_off = 14'h0000;
    bank_base = '0;
    case (mode)
      MODE_LOW, MODE_MED: begin
        row_off = 14'(scan_q[8:2] * BYTES_ROW); // R2 R3 bank row = scan/4
        bank_base = scan_q[1] ? BANK_STEP : '0; // R3
        bank_base = bank_base + (ctrl_q[PAGE_BIT] && ctrl_q[MEM64_BIT] ?
          BASE_LO : BASE_HI); // R9 R10
      end
      MODE_HICOL: begin
        row_off = 14'(scan_q[8:2] * (2 * BYTES_ROW)); // R13
        case (scan_q[1:0]) // R12
          2'd0: bank_base = BASE_HI;
          2'd1: bank_base = BASE_HI + BANK16_STEP;
          2'd2: bank_base = BASE_LO;
          default: bank_base = BASE_LO + BANK16_STEP;
        endcase
      end
      default: begin
        row_off = 14'(scan_q[8:2] * BYTES_ROW);
        // Scans 0,2,1,3 modulo four sit in banks 0,1,2,3
        bank_base = (ctrl_q[PAGE_BIT] ? BASE_LO : BASE_HI) // R14
          + 17'({scan_q[0], scan_q[1]}) * BANK_STEP; // R15
      end
    endcase
  end

  // Fetch sequencer: one byte per 8 or 4 pixels
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= S_IDLE;
      col_q <= 8'h00;
      scan_q <= 9'h000;
      req_q <= 1'b0;
      ld_q <= 1'b0;
      addr_q <= '0;
      shift_q <= 8'h00;
      pix_q <= 3'h0;
    end else begin
      req_q <= 1'b0;
      ld_q <= req_q;
      case (st_q)
        S_IDLE: begin
          if (scan_start_i && scan_i < 9'(SCANS)) begin
            scan_q <= scan_i;
            col_q <= 8'h00;
            st_q <= S_FETCH;
          end
        end
        S_FETCH: begin
          req_q <= 1'b1;
          addr_q <= ADDR_W'(bank_base + {3'h0, row_off} + {9'h000, col_q}
            + {start_q, 1'b0}); // R4 R8
          st_q <= S_SHIFT;
          pix_q <= two_bit ? 3'd4 : 3'd0;
        end
        S_SHIFT: begin
          // Memory answers in the cycle after the request pulse
          if (req_q) begin
            shift_q <= shift_q;
          end else if (ld_q) begin
            shift_q <= vmem_data_i;
          end else begin
            shift_q <= two_bit ? {shift_q[5:0], 2'b00}
                               : {shift_q[6:0], 1'b0}; // R21
            pix_q <= pix_q + 3'd1;
            if (pix_q == 3'd7) begin
              col_q <= col_q + 8'd1;
              st_q <= (col_q == col_last) ? S_IDLE : S_FETCH;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  assign vmem_addr_o = addr_q;
  assign vmem_req_o = req_q;

  // Pixel decode to guns
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {r_q, g_q, b_q, i_q, v_q} <= 5'b00000;
    end else begin
      v_q <= (st_q == S_SHIFT) && !req_q && !ld_q;
      if (two_bit) begin
        if (shift_q[7:6] == 2'b00) begin
          {r_q, g_q, b_q} <= colsel_q[2:0]; // R5 R20
          i_q <= colsel_q[3];
        end else begin
          r_q <= shift_q[7]; // R5 R13
          g_q <= shift_q[6];
          b_q <= ctrl_q[MONO_BIT] ? ~shift_q[7] | colsel_q[PAL_BIT]
                                  : colsel_q[PAL_BIT]; // R6 R7
          i_q <= colsel_q[INTEN_BIT];
        end
      end else begin
        {r_q, g_q, b_q, i_q} <= {4{shift_q[7]}}; // R11 R14
      end
    end
  end
  assign {red_o, green_o, blue_o, inten_o, pixel_valid_o} =
    {r_q, g_q, b_q, i_q, v_q};
  assign crtc_we_o = cwe_q;
  assign crtc_reg_o = creg_q;
  assign crtc_data_o = cdat_q;
endmodule

// ==== hdl/gfx_pkg.sv ====
// Constants for the graphics address and pixel decode block.
// Assumes a 40 MHz pixel clock and Avalon-MM register access.
package gfx_pkg;
  // Register word byte addresses
  localparam logic [6:0] CTRL_OFS = 7'h00;
  localparam logic [6:0] COLSEL_OFS = 7'h04;
  localparam logic [6:0] START_OFS = 7'h08;
  localparam logic [6:0] CRTC_IDX_OFS = 7'h0c;
  localparam logic [6:0] CRTC_DAT_OFS = 7'h10;
  // Control register fields
  localparam int MODE_LSB = 0;
  localparam int MONO_BIT = 2;
  localparam int MEM64_BIT = 3;
  localparam int PAGE_BIT = 7;
  // Colour select fields
  localparam int PAL_BIT = 5;
  localparam int INTEN_BIT = 4;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] COLSEL_RST = 8'h00;
  localparam logic [13:0] START_RST = 14'h0000;
  // Memory layout (word address offsets, bytes)
  localparam logic [16:0] BASE_HI = 17'h10000; // 0xB8000 window
  localparam logic [16:0] BASE_LO = 17'h00000; // 0xA8000 window
  localparam logic [16:0] BANK_STEP = 17'h02000;
  localparam logic [16:0] BANK16_STEP = 17'h04000;
  localparam logic [16:0] HALF_STEP = 17'h08000;
  localparam logic [12:0] BANK_USED = 13'h1f40;
  // Raster sizes
  localparam int COLS_LOW = 320;
  localparam int COLS_HIGH = 640;
  localparam int ROWS_LOW = 200;
  localparam int SCANS = 400;
  localparam int BYTES_ROW = 80;
  // Cursor registers and timing register range
  localparam logic [4:0] CUR_START_REG = 5'h0a;
  localparam logic [4:0] CUR_END_REG = 5'h0b;
  localparam logic [4:0] TIMING_LAST = 5'h09;
  typedef enum logic [1:0] {
    MODE_LOW, MODE_MED, MODE_HICOL, MODE_HIMONO
  } gfx_mode_e;
  // Adapter values for timing registers 0..9, per 200 or 400 row modes
  localparam logic [7:0] TIM200 [10] = '{8'h34, 8'h28, 8'h2c, 8'h05,
    8'h68, 8'h00, 8'h64, 8'h64, 8'h00, 8'h03};
  localparam logic [7:0] TIM400 [10] = '{8'h69, 8'h50, 8'h58, 8'h0a,
    8'h68, 8'h00, 8'h64, 8'h64, 8'h00, 8'h03};
endpackage

// ==== testbench/vmem_model.sv ====
// Video memory stand-in for the fetch port.
// Assumes fetch requests are one-cycle pulses.
`timescale 1ns/1ps
module vmem_model (
  input wire logic clock_i,
  input wire logic req_i,
  input wire logic [7:0] byte_i,
  output logic [7:0] data_o = 8'h00
);
  // Staged byte after a fetch, else a toggling bus
  always @(posedge clock_i) begin
    data_o <= req_i ? byte_i : ~data_o;
  end
endmodule

// ==== testbench/gfx_addr_pixel_assertions.sv ====
// Port checker: bus handshake, controller filter, fetch window.
// Assumes one clock domain and word addresses 0 to 4.
`timescale 1ns/1ps
module gfx_addr_pixel_assertions
  import gfx_pkg::*;
#(
  parameter int ADDR_W = 17
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [ADDR_W-1:0] vmem_addr_o,
  input wire logic vmem_req_o,
  input wire logic crtc_we_o,
  input wire logic [4:0] crtc_reg_o,
  input wire logic [7:0] crtc_data_o
);
  logic [4:0] idx_q;
  logic [7:0] dat_q;
  logic [1:0] mode_q;
  logic acc_q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence wr_acc(logic [4:0] a);
    avs_write_i && !avs_waitrequest_o && avs_address_i == a;
  endsequence
  // What the block should have latched from accepted writes
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idx_q <= 5'h00;
      dat_q <= 8'h00;
      mode_q <= 2'h0;
      acc_q <= 1'b0;
    end else begin
      acc_q <= avs_write_i && !avs_waitrequest_o && avs_address_i == 5'h04;
      if (avs_write_i && !avs_waitrequest_o) begin
        if (avs_address_i == 5'h03) idx_q <= avs_writedata_i[4:0];
        if (avs_address_i == 5'h04) dat_q <= avs_writedata_i[7:0];
        if (avs_address_i == 5'h00) mode_q <= avs_writedata_i[1:0];
      end
    end
  end
  chk_wait_answer: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
  chk_wait_idle: assert property (!avs_read_i && !avs_write_i
    |=> avs_waitrequest_o) else $error("stray answer");
  chk_unmapped_read: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i > 5'h04 |-> avs_readdata_o == 32'h0) else $error("rd");
  chk_timing_fixed: assert property (
    wr_acc(5'h04) ##0 idx_q <= TIMING_LAST |=> crtc_we_o && crtc_data_o ==
    (mode_q[1] ? TIM400[idx_q] : TIM200[idx_q])) else $error("timing");
  chk_cursor_double: assert property (
    wr_acc(5'h04) ##0 (idx_q == CUR_START_REG || idx_q == CUR_END_REG) ##0
    avs_writedata_i[7:3] == 5'h00 |=> crtc_data_o ==
    {4'h0, dat_q[2:0], idx_q == CUR_END_REG}) else $error("cursor");
  chk_cursor_pass: assert property (
    wr_acc(5'h04) ##0 (idx_q == CUR_START_REG || idx_q == CUR_END_REG) ##0
    avs_writedata_i[7:3] == 5'h01 |=> crtc_data_o == dat_q)
    else $error("cursor pass");
  chk_crtc_cause: assert property (crtc_we_o |-> acc_q &&
    crtc_reg_o == idx_q) else $error("crtc write");
  chk_bank_tail: assert property (vmem_req_o |->
    (mode_q == 2'h2 ? vmem_addr_o[13:0] < 14'h3f40 :
    vmem_addr_o[12:0] < BANK_USED)) else $error("bank tail");
endmodule
bind gfx_addr_pixel gfx_addr_pixel_assertions #(.ADDR_W(ADDR_W))
  u_gfx_addr_pixel_assertions (.*);

// ==== testbench/gfx_addr_pixel_tb.sv ====
// Bench for gfx_addr_pixel: bus, controller filter, fetches, pixels.
// Assumes vmem_model on the fetch port and the bound checker.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin \
  miscompares++; $display("BAD %0t %h %h", $time, a, b); end end
module gfx_addr_pixel_tb
  import gfx_pkg::*;
;
  logic clock_i = 1'b0, rstn_i = 1'b0, rd = 1'b0, wr = 1'b0, go = 1'b0;
  logic [4:0] adr = 5'h00, creg;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [8:0] scan = 9'h000;
  logic [7:0] vb = 8'h00, vd, cdat;
  logic [16:0] va;
  logic wt, vreq, r, g, b, pv, cwe;
  int miscompares = 0, checks = 0;
  // Bank base per mode row and scan modulo four
  localparam logic [16:0] BANKS [16] = '{17'h10000, 17'h10000, 17'h12000,
    17'h12000, 17'h10000, 17'h14000, 17'h00000, 17'h04000, 17'h10000,
    17'h14000, 17'h12000, 17'h16000, 17'h00000, 17'h00000, 17'h02000,
    17'h02000};
  gfx_addr_pixel u_gfx_addr_pixel (.clock_i(clock_i), .rstn_i(rstn_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
    .scan_start_i(go), .scan_i(scan), .vmem_addr_o(va), .vmem_req_o(vreq),
    .vmem_data_i(vd), .red_o(r), .green_o(g), .blue_o(b), .inten_o(),
    .pixel_valid_o(pv), .crtc_we_o(cwe), .crtc_reg_o(creg),
    .crtc_data_o(cdat));
  vmem_model u_vmem_model (.clock_i(clock_i), .req_i(vreq), .byte_i(vb),
    .data_o(vd));
  // 40 MHz clock
  initial forever #12.5 clock_i = ~clock_i;
  task automatic end_sim;
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (60000) @(posedge clock_i);
    miscompares++;
    end_sim;
  end
  // One transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do begin
      @(posedge clock_i);
      n++;
    end while (wt !== 1'b0 && n < 40);
    if (wt !== 1'b0) miscompares++;
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Index then data write, then the filtered copy
  task automatic crtc(input logic [4:0] i, input logic [7:0] d, e);
    bus(1'b1, 5'h03, {27'h0, i});
    bus(1'b1, 5'h04, {24'h0, d});
    @(negedge clock_i);
    `CHK({cwe, creg, cdat}, {1'b1, i, e})
  endtask
  // Start a scan; first fetch address and, if asked, first pixel
  task automatic line(input int k, input logic [8:0] s, input logic [7:0] v,
    input logic [3:0] p);
    int n;
    n = 0;
    @(posedge clock_i);
    vb <= v;
    scan <= s;
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    do begin
      @(negedge clock_i);
      n++;
    end while (vreq !== 1'b1 && n < 40);
    `CHK(va, BANKS[k * 4 + s[1:0]] + {10'h0, s[8:2]} * (k == 1 ? 17'h0a0 : 17'h050))
    do begin
      @(negedge clock_i);
      n++;
    end while (pv !== 1'b1 && n < 200);
    `CHK(pv, 1'b1)
    if (p[3]) `CHK({r, g, b}, p[2:0])
    repeat (1300) @(posedge clock_i);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    bus(1'b0, 5'h1f, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, 5'h01, 32'h22);
    for (int i = 0; i < 10; i++) crtc(5'(i), 8'hff, TIM200[i]);
    crtc(CUR_START_REG, 8'h03, 8'h06);
    crtc(CUR_END_REG, 8'h03, 8'h07);
    crtc(CUR_END_REG, 8'h0f, 8'h0f);
    crtc(CUR_START_REG, 8'h09, 8'h09);
    line(0, 9'd0, 8'hc0, 4'hf);
    line(0, 9'd1, 8'h40, 4'hb);
    line(0, 9'd2, 8'h00, 4'ha);
    line(0, 9'd3, 8'h80, 4'hd);
    bus(1'b1, 5'h01, 32'h02);
    line(0, 9'd0, 8'hc0, 4'he);
    bus(1'b1, 5'h00, 32'h04);
    line(0, 9'd0, 8'h40, 4'hb);
    bus(1'b1, 5'h00, 32'h01);
    line(0, 9'd2, 8'h80, 4'hf);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 5'h00, k > 0 ? 32'(k + 9) : 32'h0);
      crtc(5'h00, 8'hff, k > 0 ? TIM400[0] : TIM200[0]);
      for (int s = 0; s < 5; s++)
        line(k, 9'(s < 4 ? s : 399), 8'h00, 4'h0);
    end
    bus(1'b1, 5'h00, 32'h88);
    line(3, 9'd2, 8'h00, 4'h0);
    end_sim;
  end
endmodule
